// ==== hdl/ring_gen_pkg.sv ====
/*
 Constants, field layouts and types of the ringing waveform generator.
 Assumes a 25 MHz system clock and an 8-bit direct register port with an
 indirect access window for the 16-bit coefficient registers.
*/
// Contract
// - sine samples from resonator, one per millisecond
// - on and off cadence timers, up to 8 s
// - timers move line between ringing and on-hook
// - line state 100 starts ringing, first burst now
// - on timer expiry stops wave, goes on-hook
// - off timer expiry rings again while enabled
// - sine coefficient cosine scaled, amplitude 96 V full
// - control bit 0 picks sine or trapezoid
// - trapezoid steps by coefficient, plateau, half period
// - phase register: sine start phase, trapezoid half period
// - offset added only while control bit 1 set
// - offset scaled 2^15 equals 96 volts
// - control register holds shape, offset, timer, oscillator
// - on count at 48/49, off count 50/51
// - four-bit common-mode bias adjust while ringing
// - indirect registers reached through window 28-31
// - cadence counts in 125 us steps
// - one counter: on period, clear, off period
// - common-mode setting weighs 1.5 V per step
package ring_gen_pkg;
    localparam int CLK_PERIOD_NS   = 40;
    localparam int TICK_NS         = 125000;
    localparam int UPDATE_NS       = 1000000;
    localparam int TICK_CYCLES     = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TICKS_PER_UPDATE = UPDATE_NS / TICK_NS;

    // direct registers
    localparam logic [6:0] A_IDAT_LO   = 7'h1c;
    localparam logic [6:0] A_IDAT_HI   = 7'h1d;
    localparam logic [6:0] A_IADDR     = 7'h1e;
    localparam logic [6:0] A_ICMD      = 7'h1f;
    localparam logic [6:0] A_CTRL      = 7'h22;
    localparam logic [6:0] A_ON_LO     = 7'h30;
    localparam logic [6:0] A_ON_HI     = 7'h31;
    localparam logic [6:0] A_OFF_LO    = 7'h32;
    localparam logic [6:0] A_OFF_HI    = 7'h33;
    localparam logic [6:0] A_LINE      = 7'h40;
    localparam logic [6:0] A_HBAT      = 7'h4a;
    // indirect registers
    localparam logic [7:0] I_OFFSET    = 8'h13;
    localparam logic [7:0] I_COEFF     = 8'h14;
    localparam logic [7:0] I_AMP       = 8'h15;
    localparam logic [7:0] I_PHASE     = 8'h16;
    localparam logic [7:0] I_CMADJ     = 8'h28;

    localparam int ICMD_WRITE_BIT      = 0;
    localparam logic [2:0] LINE_RINGING = 3'b100;
    localparam logic [2:0] LINE_ON_HOOK = 3'b010;
    localparam logic [7:0]  RESET_BYTE = 8'h00;
    localparam logic [15:0] RESET_WORD = 16'h0000;

    // control register layout, bit 0 at the bottom
    typedef struct packed {
        logic [2:0] spare;
        logic       osc_en;
        logic       off_timer_en;
        logic       on_timer_en;
        logic       offset_en;
        logic       shape_trap;
    } ring_ctrl_s;

    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_ON   = 2'b01,
        PH_OFF  = 2'b10
    } cad_phase_e;
endpackage

// ==== hdl/ring_wave_gen.sv ====
/*
 Ringing waveform generator: registers, indirect window, cadence timer,
 sine resonator and trapezoid ramp, dc offset adder.
 Assumes a host port that presents one synchronous access per strobe.
*/
`timescale 1ns/100ps
module ring_wave_gen
    import ring_gen_pkg::*;
(
    // clock and reset
    input  wire logic        MCLK,
    input  wire logic        RST,
    // direct register port
    input  wire logic [6:0]  REG_ADDR,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    input  wire logic [7:0]  REG_WDATA,
    output logic      [7:0]  REG_RDATA,
    // line side
    output logic      [15:0] RING_SAMPLE,
    output logic      [2:0]  LINE_STATE,
    output logic      [3:0]  RING_CM_BIAS,
    output logic      [7:0]  BATT_HIGH_LEVEL
);
    ring_ctrl_s  ctrl_reg,   ctrl_next;
    logic [2:0]  lsel_reg,   lsel_next;
    logic [15:0] on_reg,     on_next;
    logic [15:0] off_reg,    off_next;
    logic [7:0]  hbat_reg,   hbat_next;
    logic [7:0]  iaddr_reg,  iaddr_next;
    logic [15:0] idat_reg,   idat_next;
    logic [15:0] offs_reg,   offs_next;
    logic [15:0] coef_reg,   coef_next;
    logic [15:0] amp_reg,    amp_next;
    logic [15:0] phs_reg,    phs_next;
    logic [3:0]  cm_reg,     cm_next;
    logic [7:0]  rdat_reg,   rdat_next;
    logic [11:0] tick_cnt,   tick_cnt_next;
    logic [2:0]  upd_cnt,    upd_cnt_next;
    cad_phase_e  ph_reg,     ph_next;
    logic [15:0] cad_cnt,    cad_cnt_next;
    logic [15:0] y1_reg,     y1_next;
    logic [15:0] y2_reg,     y2_next;
    logic [15:0] half_cnt,   half_cnt_next;
    logic        dir_up,     dir_up_next;
    logic [15:0] samp_reg,   samp_next;
    logic [2:0]  line_reg,   line_next;

    logic        tick;
    logic        ms_tick;
    logic        ring_sel;
    logic        run;
    logic        seed;
    logic [7:0]  rd_mux;
    logic [15:0] ind_rd;

    function automatic logic [15:0] sat16(input logic signed [17:0] v);
        if (v > 18'sd32767)
            return 16'h7fff;
        else if (v < -18'sd32768)
            return 16'h8000;
        else
            return v[15:0];
    endfunction

    assign tick     = (tick_cnt == 12'(TICK_CYCLES - 1));
    assign ms_tick  = tick && (upd_cnt == 3'(TICKS_PER_UPDATE - 1));
    assign ring_sel = (lsel_reg == LINE_RINGING);
    assign run      = ring_sel && (ctrl_reg.on_timer_en ? (ph_reg == PH_ON) : ctrl_reg.osc_en);
    assign seed     = REG_WR && (REG_ADDR == A_LINE) && (REG_WDATA[2:0] == LINE_RINGING)
                      && !ring_sel;

    always_comb begin
        case (iaddr_reg)
            I_OFFSET: ind_rd = offs_reg;
            I_COEFF:  ind_rd = coef_reg;
            I_AMP:    ind_rd = amp_reg;
            I_PHASE:  ind_rd = phs_reg;
            I_CMADJ:  ind_rd = {12'h000, cm_reg};
            default:  ind_rd = RESET_WORD;
        endcase
    end

    always_comb begin
        if (REG_ADDR == A_IDAT_LO)
            rd_mux = idat_reg[7:0];
        else if (REG_ADDR == A_IDAT_HI)
            rd_mux = idat_reg[15:8];
        else if (REG_ADDR == A_IADDR)
            rd_mux = iaddr_reg;
        else if (REG_ADDR == A_CTRL)
            rd_mux = ctrl_reg;
        else if (REG_ADDR == A_ON_LO)
            rd_mux = on_reg[7:0];
        else if (REG_ADDR == A_ON_HI)
            rd_mux = on_reg[15:8];
        else if (REG_ADDR == A_OFF_LO)
            rd_mux = off_reg[7:0];
        else if (REG_ADDR == A_OFF_HI)
            rd_mux = off_reg[15:8];
        else if (REG_ADDR == A_LINE)
            rd_mux = {1'b0, line_reg, 1'b0, lsel_reg};
        else if (REG_ADDR == A_HBAT)
            rd_mux = hbat_reg;
        else
            rd_mux = RESET_BYTE;
    end

    // register file and indirect window
    always_comb begin
        ctrl_next  = ctrl_reg;
        lsel_next  = lsel_reg;
        on_next    = on_reg;
        off_next   = off_reg;
        hbat_next  = hbat_reg;
        iaddr_next = iaddr_reg;
        idat_next  = idat_reg;
        offs_next  = offs_reg;
        coef_next  = coef_reg;
        amp_next   = amp_reg;
        phs_next   = phs_reg;
        cm_next    = cm_reg;
        rdat_next  = REG_RD ? rd_mux : rdat_reg;
        if (REG_WR) begin
            if (REG_ADDR == A_IDAT_LO)
                idat_next[7:0] = REG_WDATA;
            else if (REG_ADDR == A_IDAT_HI)
                idat_next[15:8] = REG_WDATA;
            else if (REG_ADDR == A_IADDR)
                iaddr_next = REG_WDATA;
            else if (REG_ADDR == A_ICMD) begin
                if (REG_WDATA[ICMD_WRITE_BIT]) begin
                    case (iaddr_reg)
                        I_OFFSET: offs_next = idat_reg;
                        I_COEFF:  coef_next = idat_reg;
                        I_AMP:    amp_next  = idat_reg;
                        I_PHASE:  phs_next  = idat_reg;
                        I_CMADJ:  cm_next   = idat_reg[3:0];
                        default:  ;
                    endcase
                end else
                    idat_next = ind_rd;
            end else if (REG_ADDR == A_CTRL)
                ctrl_next = REG_WDATA;
            else if (REG_ADDR == A_ON_LO)
                on_next[7:0] = REG_WDATA;
            else if (REG_ADDR == A_ON_HI)
                on_next[15:8] = REG_WDATA;
            else if (REG_ADDR == A_OFF_LO)
                off_next[7:0] = REG_WDATA;
            else if (REG_ADDR == A_OFF_HI)
                off_next[15:8] = REG_WDATA;
            else if (REG_ADDR == A_LINE)
                lsel_next = REG_WDATA[2:0];
            else if (REG_ADDR == A_HBAT)
                hbat_next = REG_WDATA;
        end
    end

    // cadence: one counter serves both periods
    always_comb begin
        tick_cnt_next = tick ? 12'h000 : tick_cnt + 12'h001;
        upd_cnt_next  = ms_tick ? 3'h0 : (tick ? upd_cnt + 3'h1 : upd_cnt);
        ph_next       = ph_reg;
        cad_cnt_next  = cad_cnt;
        if (seed) begin
            ph_next      = PH_ON;
            cad_cnt_next = RESET_WORD;
        end else if (!ring_sel)
            ph_next = PH_IDLE;
        else if (tick) begin
            if (ph_reg == PH_ON && ctrl_reg.on_timer_en) begin
                if (cad_cnt >= on_reg) begin
                    ph_next      = PH_OFF;
                    cad_cnt_next = RESET_WORD;
                end else
                    cad_cnt_next = cad_cnt + 16'h0001;
            end else if (ph_reg == PH_OFF && ctrl_reg.off_timer_en
                         && ctrl_reg.on_timer_en) begin
                if (cad_cnt >= off_reg) begin
                    ph_next      = PH_ON;
                    cad_cnt_next = RESET_WORD;
                end else
                    cad_cnt_next = cad_cnt + 16'h0001;
            end
        end
        // silent half of the cadence still carries voice
        if (!ring_sel)
            line_next = lsel_reg;
        else if (ctrl_reg.on_timer_en && ph_reg == PH_OFF)
            line_next = LINE_ON_HOOK;
        else
            line_next = LINE_RINGING;
    end

    // waveform engine
    logic signed [31:0] prod;
    logic signed [17:0] sine_raw;
    logic signed [17:0] ramp_raw;
    logic signed [17:0] amp_s;
    logic signed [17:0] sum_raw;

    always_comb begin
        prod     = $signed(coef_reg) * $signed(y1_reg);
        sine_raw = 18'(prod >>> 14) - 18'($signed(y2_reg));
        amp_s    = 18'($signed(amp_reg));
        ramp_raw = dir_up ? 18'($signed(y1_reg)) + 18'($signed(coef_reg))
                          : 18'($signed(y1_reg)) - 18'($signed(coef_reg));
        y1_next       = y1_reg;
        y2_next       = y2_reg;
        half_cnt_next = half_cnt;
        dir_up_next   = dir_up;
        if (!run || seed) begin
            // restart sine from programmed phase, trapezoid from zero, so each burst begins alike
            y1_next       = ctrl_reg.shape_trap ? RESET_WORD : phs_reg;
            y2_next       = -amp_reg;
            half_cnt_next = RESET_WORD;
            dir_up_next   = 1'b1;
        end else if (!ctrl_reg.shape_trap) begin
            if (ms_tick) begin
                y2_next = y1_reg;
                y1_next = sat16(sine_raw);
            end
        end else if (tick) begin
            if (dir_up && ramp_raw > amp_s)
                y1_next = amp_reg;
            else if (!dir_up && ramp_raw < -amp_s)
                y1_next = -amp_reg;
            else
                y1_next = ramp_raw[15:0];
            if (half_cnt + 16'h0001 >= phs_reg) begin
                half_cnt_next = RESET_WORD;
                dir_up_next   = !dir_up;
            end else
                half_cnt_next = half_cnt + 16'h0001;
        end
        sum_raw = 18'($signed(y1_reg))
                  + (ctrl_reg.offset_en ? 18'($signed(offs_reg)) : 18'sd0);
        samp_next = run ? sat16(sum_raw) : RESET_WORD;
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            ctrl_reg  <= RESET_BYTE;
            lsel_reg  <= 3'b000;
            on_reg    <= RESET_WORD;
            off_reg   <= RESET_WORD;
            hbat_reg  <= RESET_BYTE;
            iaddr_reg <= RESET_BYTE;
            idat_reg  <= RESET_WORD;
            offs_reg  <= RESET_WORD;
            coef_reg  <= RESET_WORD;
            amp_reg   <= RESET_WORD;
            phs_reg   <= RESET_WORD;
            cm_reg    <= 4'h0;
            rdat_reg  <= RESET_BYTE;
            tick_cnt  <= 12'h000;
            upd_cnt   <= 3'h0;
            ph_reg    <= PH_IDLE;
            cad_cnt   <= RESET_WORD;
            y1_reg    <= RESET_WORD;
            y2_reg    <= RESET_WORD;
            half_cnt  <= RESET_WORD;
            dir_up    <= 1'b1;
            samp_reg  <= RESET_WORD;
            line_reg  <= 3'b000;
        end else begin
            ctrl_reg  <= ctrl_next;
            lsel_reg  <= lsel_next;
            on_reg    <= on_next;
            off_reg   <= off_next;
            hbat_reg  <= hbat_next;
            iaddr_reg <= iaddr_next;
            idat_reg  <= idat_next;
            offs_reg  <= offs_next;
            coef_reg  <= coef_next;
            amp_reg   <= amp_next;
            phs_reg   <= phs_next;
            cm_reg    <= cm_next;
            rdat_reg  <= rdat_next;
            tick_cnt  <= tick_cnt_next;
            upd_cnt   <= upd_cnt_next;
            ph_reg    <= ph_next;
            cad_cnt   <= cad_cnt_next;
            y1_reg    <= y1_next;
            y2_reg    <= y2_next;
            half_cnt  <= half_cnt_next;
            dir_up    <= dir_up_next;
            samp_reg  <= samp_next;
            line_reg  <= line_next;
        end
    end

    assign REG_RDATA       = rdat_reg;
    assign RING_SAMPLE     = samp_reg;
    assign LINE_STATE      = line_reg;
    assign RING_CM_BIAS    = cm_reg;
    assign BATT_HIGH_LEVEL = hbat_reg;

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    sequence s_on_expiry;
        tick && ph_reg == PH_ON && ctrl_reg.on_timer_en && cad_cnt >= on_reg
        && ring_sel && !REG_WR;
    endsequence
    sequence s_off_expiry;
        tick && ph_reg == PH_OFF && ctrl_reg.on_timer_en && ctrl_reg.off_timer_en
        && cad_cnt >= off_reg && ring_sel && !REG_WR;
    endsequence

    a_ring_entry: assert property (seed |=> ph_reg == PH_ON && cad_cnt == 16'h0000
        ##1 LINE_STATE == LINE_RINGING)
        else $error("ringing did not start on line state write");
    a_on_expire: assert property (s_on_expiry |=> ph_reg == PH_OFF && cad_cnt == 16'h0000
        ##1 LINE_STATE == LINE_ON_HOOK)
        else $error("on period expiry did not go on-hook");
    a_off_expire: assert property (s_off_expiry |=> ph_reg == PH_ON)
        else $error("off period expiry did not restart ringing");
    a_tick_period: assert property (tick |-> tick_cnt == 12'd3124
        ##1 tick_cnt == 12'h000 && upd_cnt == $past(upd_cnt) + 3'h1)
        else $error("cadence step is not 3125 cycles");
    a_sine_rate: assert property (!ctrl_reg.shape_trap && run && !$past(ms_tick)
        && $past(run) && !$past(seed) && $stable(ctrl_reg) |-> $stable(y1_reg))
        else $error("sine sample moved between millisecond updates");
    a_offset_gate: assert property (run && !ctrl_reg.offset_en && !y1_reg[15]
        |=> RING_SAMPLE == $past(y1_reg))
        else $error("offset applied while disabled");
    a_trap_bound: assert property (ctrl_reg.shape_trap && run && tick && !amp_reg[15]
        && !seed |=> $signed(y1_reg) <= $signed(amp_reg))
        else $error("trapezoid exceeded plateau");
    a_quiet_idle: assert property ((!ring_sel || (ctrl_reg.on_timer_en && ph_reg != PH_ON))
        |=> RING_SAMPLE == 16'h0000)
        else $error("waveform present outside ringing");
    a_ind_read: assert property (REG_WR && REG_ADDR == A_ICMD
        && !REG_WDATA[ICMD_WRITE_BIT] && iaddr_reg == I_CMADJ
        |=> idat_reg == {12'h000, cm_reg})
        else $error("indirect read returned wrong data");
endmodule

// ==== verif/ring_wave_gen_tb.sv ====
/*
 Self-checking bench of the ringing waveform generator: register access,
 indirect window, sine seed and update, trapezoid cadence with offset.
 Assumes the design in hdl/ and its package; the bench drives the host port.
*/
`timescale 1ns/100ps
module ring_wave_gen_tb
    import ring_gen_pkg::*;
;
    logic        MCLK;
    logic        RST;
    logic [6:0]  REG_ADDR;
    logic        REG_WR;
    logic        REG_RD;
    logic [7:0]  REG_WDATA;
    logic [7:0]  REG_RDATA;
    logic [15:0] RING_SAMPLE;
    logic [2:0]  LINE_STATE;
    logic [3:0]  RING_CM_BIAS;
    logic [7:0]  BATT_HIGH_LEVEL;
    int          miscompares;
    int          num_checks;
    logic [7:0]  exp_q[$];
    logic        rd_p1;
    logic        rd_p2;
    logic [31:0] seed;
    logic        trap_on;
    logic [15:0] trap_max;
    logic [6:0]  addrs[12];
    logic [7:0]  wdat[12];
    int          n;

    ring_wave_gen u_dut (.MCLK(MCLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
        .REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
        .RING_SAMPLE(RING_SAMPLE), .LINE_STATE(LINE_STATE), .RING_CM_BIAS(RING_CM_BIAS),
        .BATT_HIGH_LEVEL(BATT_HIGH_LEVEL));

    initial begin
        MCLK = 1'b0;
        forever #20 MCLK = ~MCLK;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk_out(input string nm, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
        num_checks++;
        if (g < lo || g > hi) begin
            miscompares++;
            $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask

    // a gap cycle after each strobe keeps every pulse one cycle wide
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        REG_ADDR = a;
        REG_WDATA = d;
        REG_WR = 1'b1;
        @(posedge MCLK) #1;
        REG_WR = 1'b0;
        @(posedge MCLK) #1;
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        REG_ADDR = a;
        REG_RD = 1'b1;
        @(posedge MCLK) #1;
        REG_RD = 1'b0;
        @(posedge MCLK) #1;
    endtask

    task automatic iwr(input logic [7:0] ia, input logic [15:0] d);
        wr(A_IDAT_LO, d[7:0]);
        wr(A_IDAT_HI, d[15:8]);
        wr(A_IADDR, ia);
        wr(A_ICMD, 8'h01);
    endtask

    task automatic ird(input logic [7:0] ia, input logic [15:0] e);
        wr(A_IADDR, ia);
        wr(A_ICMD, 8'h00);
        rd(A_IDAT_LO, e[7:0]);
        rd(A_IDAT_HI, e[15:8]);
    endtask

    task automatic wait_line(input logic [2:0] e, input int lim, output int cnt);
        cnt = 0;
        while (LINE_STATE !== e) begin
            @(posedge MCLK) #1;
            cnt++;
            if (cnt > lim) begin
                miscompares++;
                $display("[ERR] line_state expected %h seen %h", e, LINE_STATE);
                test_done();
            end
        end
    endtask

    // read data lands on the strobe edge and is checked one cycle later
    always @(posedge MCLK) begin
        #2;
        if (rd_p2) begin
            chk_out("reg_rdata", {8'h00, exp_q.pop_front()}, {8'h00, REG_RDATA});
        end
        rd_p2 = rd_p1;
        rd_p1 = REG_RD;
        if (trap_on && LINE_STATE === LINE_RINGING) begin
            if ($signed(RING_SAMPLE) > $signed(trap_max)) trap_max = RING_SAMPLE;
            if ($signed(RING_SAMPLE - 16'h0020) > 16'sh0100 ||
                $signed(RING_SAMPLE - 16'h0020) < -16'sh0100 ||
                (RING_SAMPLE - 16'h0020) % 16'h0040 != 0) begin
                chk_out("trap_sample", 16'h0020, RING_SAMPLE);
            end
        end
    end

    initial begin
        RST = 1'b1;
        REG_ADDR = 7'h00;
        REG_WR = 1'b0;
        REG_RD = 1'b0;
        REG_WDATA = 8'h00;
        miscompares = 0;
        num_checks = 0;
        rd_p1 = 1'b0;
        rd_p2 = 1'b0;
        trap_on = 1'b0;
        trap_max = 16'h8000;
        seed = 32'hc10a5dbb;
        addrs = '{A_CTRL, A_ON_LO, A_ON_HI, A_OFF_LO, A_OFF_HI, A_HBAT,
                  A_IDAT_LO, A_IDAT_HI, A_IADDR, A_ICMD, A_LINE, 7'h05};
        repeat (10) @(posedge MCLK);
        #1;
        chk_out("reset_outs", 16'h0000, {RING_SAMPLE[11:0], 1'b0, LINE_STATE});
        RST = 1'b0;
        for (int i = 0; i < 12; i++) rd(addrs[i], RESET_BYTE);
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            wdat[i] = (i == 0) ? (seed[7:0] & 8'h0e) : (i == 5) ? (seed[7:0] & 8'h3f) : seed[7:0];
            wr(addrs[i], wdat[i]);
        end
        wr(7'h05, 8'h5a);
        for (int i = 0; i < 6; i++) rd(addrs[i], wdat[i]);
        rd(7'h05, 8'h00);
        chk_out("batt_high", {8'h00, wdat[5]}, {8'h00, BATT_HIGH_LEVEL});
        wr(A_LINE, 8'h01);
        chk_out("line_idle", 16'h0001, {13'h0, LINE_STATE});
        rd(A_LINE, 8'h11);
        // indirect window, every coefficient register
        seed = xs(seed);
        iwr(I_CMADJ, {12'h000, seed[3:0]});
        chk_out("cm_bias", {12'h000, seed[3:0]}, {12'h000, RING_CM_BIAS});
        ird(I_CMADJ, {12'h000, seed[3:0]});
        for (int i = 0; i < 4; i++) begin
            iwr(I_OFFSET + i[7:0], seed[31:16] ^ i[15:0]);
            ird(I_OFFSET + i[7:0], seed[31:16] ^ i[15:0]);
        end
        // sine: c=0.5, y1=phase, y2=-amplitude, timers off so osc gates
        iwr(I_COEFF, 16'h4000);
        iwr(I_AMP, 16'h0100);
        iwr(I_PHASE, 16'h0123);
        wr(A_CTRL, 8'h10);
        // checked two edges after the write, before a millisecond update can land
        wr(A_LINE, 8'h04);
        chk_out("ring_state", {13'h0, LINE_RINGING}, {13'h0, LINE_STATE});
        chk_out("sine_seed", 16'h0123, RING_SAMPLE);
        n = 0;
        while (RING_SAMPLE === 16'h0123 && n < 26000) begin
            @(posedge MCLK) #1;
            n++;
        end
        chk_rng("sine_update", 1, 25001, n);
        chk_out("sine_next", 16'h0223, RING_SAMPLE);
        wr(A_LINE, 8'h00);
        wait_line(3'b000, 4, n);
        @(posedge MCLK) #1;
        chk_out("idle_sample", 16'h0000, RING_SAMPLE);
        // trapezoid with offset, 10 ticks on, 2 ticks off
        iwr(I_OFFSET, 16'h0020);
        iwr(I_COEFF, 16'h0040);
        iwr(I_PHASE, 16'h0004);
        wr(A_ON_LO, 8'h09);
        wr(A_ON_HI, 8'h00);
        wr(A_OFF_LO, 8'h01);
        wr(A_OFF_HI, 8'h00);
        wr(A_CTRL, 8'h1f);
        wr(A_LINE, 8'h04);
        chk_out("trap_seed", 16'h0020, RING_SAMPLE);
        trap_on = 1'b1;
        wait_line(LINE_ON_HOOK, 35000, n);
        chk_rng("on_period", 9 * 3125, 10 * 3125 + 2, n);
        @(posedge MCLK) #1;
        @(posedge MCLK) #1;
        chk_out("off_sample", 16'h0000, RING_SAMPLE);
        wait_line(LINE_RINGING, 7000, n);
        chk_rng("off_period", 2 * 3125 - 4, 2 * 3125 + 2, n);
        rd(A_LINE, 8'h44);
        chk_out("trap_peak", 16'h0120, trap_max);
        trap_on = 1'b0;
        wr(A_LINE, 8'h00);
        wait_line(3'b000, 4, n);
        repeat (3) @(posedge MCLK);
        test_done();
    end
endmodule
